//--- core/pss_pkg.sv
/*
 * Package for the profiling state save/restore block: register map, image
 * word layout, control field positions and the state carrier types.
 * Assumes 32-bit AXI4-Lite data and an 8-bit byte address.
 */
package pss_pkg;

    localparam int unsigned ADDR_W = 8;

    // image words (byte address = 4 * index), 128-byte image
    localparam int unsigned IMG_WORDS = 32;
    localparam logic [5:0] W_CBADDR_LO = 6'h00;
    localparam logic [5:0] W_CBADDR_HI = 6'h01;
    localparam logic [5:0] W_FLAGS = 6'h02;
    localparam logic [5:0] W_HEAD = 6'h03;
    localparam logic [5:0] W_BASE_LO = 6'h04;
    localparam logic [5:0] W_BASE_HI = 6'h05;
    localparam logic [5:0] W_SIZE = 6'h06;
    localparam logic [5:0] W_FILT = 6'h07;
    localparam logic [5:0] W_REC = 6'h08;
    localparam logic [5:0] W_CNT = 6'h10;
    localparam int unsigned REC_WORDS = 8;
    localparam int unsigned NUM_EVT = 6;
    localparam int unsigned SIZE_W = 28;
    // image placement inside the extended save area
    localparam int unsigned IMG_BYTES = 128;
    localparam int unsigned IMG_OFFSET = 832;
    localparam int unsigned FEATURE_BIT = 62;

    // control and status registers
    localparam logic [5:0] R_CTRL = 6'h20;
    localparam logic [5:0] R_SEG_LIMIT = 6'h21;
    localparam logic [5:0] R_SEG_BASE = 6'h22;
    localparam logic [5:0] R_CFG = 6'h23;
    localparam logic [5:0] R_CMD = 6'h24;
    localparam logic [5:0] R_STATUS = 6'h25;
    localparam logic [5:0] R_HEAD = 6'h26;
    localparam logic [5:0] R_SIZE = 6'h27;
    localparam logic [5:0] R_LAST = 6'h27;

    // control field positions
    localparam int unsigned C_XFM = 0;
    localparam int unsigned C_REQ = 1;
    localparam int unsigned C_BITMAP = 2;
    localparam int unsigned C_PRIV_LO = 4;
    localparam int unsigned C_LONG = 6;
    localparam int unsigned C_SEG_RO = 7;
    // command bits
    localparam int unsigned K_SAVE = 0;
    localparam int unsigned K_RESTORE = 1;
    // status bits
    localparam int unsigned S_EN = 0;
    localparam int unsigned S_GP = 1;
    localparam int unsigned S_PEND = 2;
    localparam int unsigned S_FLAGS_LO = 4;

    localparam logic [1:0] PRIV_USER = 2'h3;
    localparam logic [1:0] PRIV_KERNEL = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_SAVE = 2'b01,
        OP_RESTORE = 2'b10
    } pss_op_t;

    // internal profiling state
    typedef struct packed {
        logic [63:0] cbaddr;
        logic [NUM_EVT:1] active;
        logic [31:0] head;
        logic [63:0] base;
        logic [SIZE_W-1:0] size;
        logic [31:0] filters;
        logic [REC_WORDS-1:0][31:0] record;
        logic pending;
        logic [NUM_EVT:1][31:0] count;
    } pss_prof_t;

    typedef struct packed {
        pss_prof_t p;
        logic [IMG_WORDS-1:0][31:0] img;
        logic xfm;
        logic req;
        logic bitmap;
        logic [1:0] priv;
        logic long_mode;
        logic seg_ro;
        logic [31:0] seg_limit;
        logic [31:0] seg_base;
        logic [NUM_EVT:1] avail;
        pss_op_t op;
        logic gp_sticky;
        logic gp_pulse;
        logic store_pulse;
        logic en;
        logic aw_rdy;
        logic aw_have;
        logic [ADDR_W-1:0] awaddr;
        logic w_rdy;
        logic w_have;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic ar_rdy;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } pss_state_t;

endpackage : pss_pkg

//--- core/pss_profiling_state_save_restore.sv
/*
 * Profiling state holder with the save and restore engine of the extended
 * state mechanism, reached over an AXI4-Lite slave. Software writes the
 * 128-byte image and the context registers, then issues save or restore.
 * Assumes one clock, synchronous active-low reset, one write and one read
 * outstanding at a time.
 */
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - feature mask bit 62 gates saving and restoring of profiling state.
// - image is 128 bytes at offset 832 of the extended save area.
// - bytes 7-0 hold control block address; zero means disabled, rest ignored.
// - flag bit 0 reserved, bits 6:1 mark events 1 to 6 active.
// - head at 15-12, base 23-16, size bits 27:0 of 27-24, filters 31-28.
// - bytes 63-32 hold pending record; zero event type means none pending.
// - counters at 67-64 and 87-68, valid only when flagged; 127-88 reserved.
// - save with zero address stores nothing and clears bitmap bit 62.
// - save when enabled copies state unchecked and sets bitmap bit 62.
// - restore leaves state alone when mask bit 62 or request bit is zero.
// - bitmap bit zero with both masks set zeroes state and disables.
// - ring size below minimum disables profiling and ends the restore.
// - size and head rounded down to record size; oversized head becomes zero.
// - flagged available events get enabled and loaded; others disabled.
// - pending record loaded at restore, stored once privilege is 3.
// - restore overwrites running state without saving it.
// - restore raises no threshold interrupt; next stored record does (this block has no interrupt output, only the record_store pulse).
// - at privilege 0 addresses are reloaded without validation.
// - nonzero privilege checks lowest and highest bytes against segment.
// - failed validation disables profiling with no fault.
// - mask bit 62 zero with bitmap bit one raises general protection fault.
module pss_profiling_state_save_restore #(
    parameter int unsigned RECORD_SIZE = 32,
    parameter int unsigned RING_MIN = 64,
    parameter int unsigned CB_SIZE = 128
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [pss_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [pss_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic profiling_enabled,
    output logic gp_fault,
    output logic record_store
);

    localparam int unsigned SIZE_W_L = pss_pkg::SIZE_W;
    localparam logic [SIZE_W_L-1:0] REC_SZ = SIZE_W_L'(RECORD_SIZE);
    localparam logic [SIZE_W_L-1:0] MIN_SZ = SIZE_W_L'(RING_MIN);

    pss_pkg::pss_state_t s_q;
    pss_pkg::pss_state_t s_d;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic [SIZE_W_L-1:0] rnd(input logic [SIZE_W_L-1:0] x);
        return x - (x % REC_SZ);
    endfunction : rnd

    // store-type segment check on both ends of a range
    function automatic logic range_ok(input logic [63:0] addr, input logic [31:0] size,
                                      input logic long_mode, input logic [31:0] seg_base,
                                      input logic [31:0] seg_limit, input logic seg_ro);
        logic [63:0] lo;
        logic [63:0] top;
        lo = addr;
        if (!long_mode) begin
            lo = {32'h0000_0000, addr[31:0] - seg_base};
        end
        top = lo + {32'h0000_0000, size} - 64'h0000_0000_0000_0001;
        return !seg_ro && (lo <= {32'h0000_0000, seg_limit})
            && (top <= {32'h0000_0000, seg_limit});
    endfunction : range_ok

    function automatic logic map_ok(input logic [pss_pkg::ADDR_W-1:0] a);
        return a[7:2] <= pss_pkg::R_LAST;
    endfunction : map_ok

    always_comb begin
        logic [5:0] widx;
        logic [5:0] ridx;
        logic [SIZE_W_L-1:0] szr;
        logic [31:0] hd;
        logic [31:0] wv;
        pss_pkg::pss_prof_t np;
        widx = s_q.awaddr[7:2];
        ridx = s_axi_araddr[7:2];
        szr = '0;
        hd = '0;
        wv = '0;
        np = s_q.p;
        s_d = s_q;
        s_d.op = pss_pkg::OP_NONE;
        s_d.gp_pulse = 1'b0;
        s_d.store_pulse = 1'b0;

        // write address and data taken independently
        if (s_axi_awvalid && s_q.aw_rdy) begin
            s_d.aw_have = 1'b1;
            s_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_q.w_rdy) begin
            s_d.w_have = 1'b1;
            s_d.wdata = s_axi_wdata;
            s_d.wstrb = s_axi_wstrb;
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = map_ok(s_q.awaddr) ? pss_pkg::RESP_OKAY : pss_pkg::RESP_SLVERR;
            wv = s_q.wdata;
            if (widx < 6'(pss_pkg::IMG_WORDS)) begin
                s_d.img[widx[4:0]] = merge(s_q.img[widx[4:0]], wv, s_q.wstrb);
            end else begin
                case (widx)
                    pss_pkg::R_CTRL: begin
                        if (s_q.wstrb[0]) begin
                            s_d.xfm = wv[pss_pkg::C_XFM];
                            s_d.req = wv[pss_pkg::C_REQ];
                            s_d.bitmap = wv[pss_pkg::C_BITMAP];
                            s_d.priv = wv[pss_pkg::C_PRIV_LO +: 2];
                            s_d.long_mode = wv[pss_pkg::C_LONG];
                            s_d.seg_ro = wv[pss_pkg::C_SEG_RO];
                        end
                    end
                    pss_pkg::R_SEG_LIMIT: s_d.seg_limit = merge(s_q.seg_limit, wv, s_q.wstrb);
                    pss_pkg::R_SEG_BASE: s_d.seg_base = merge(s_q.seg_base, wv, s_q.wstrb);
                    pss_pkg::R_CFG: begin
                        if (s_q.wstrb[0]) begin
                            s_d.avail = wv[pss_pkg::NUM_EVT:1];
                        end
                    end
                    pss_pkg::R_CMD: begin
                        if (s_q.wstrb[0] && wv[pss_pkg::K_RESTORE]) begin
                            s_d.op = pss_pkg::OP_RESTORE;
                        end else if (s_q.wstrb[0] && wv[pss_pkg::K_SAVE]) begin
                            s_d.op = pss_pkg::OP_SAVE;
                        end
                    end
                    pss_pkg::R_STATUS: begin
                        if (s_q.wstrb[0] && wv[pss_pkg::S_GP]) begin
                            s_d.gp_sticky = 1'b0;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
        s_d.aw_rdy = !s_d.aw_have;
        s_d.w_rdy = !s_d.w_have;

        // read channel
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_q.ar_rdy) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = map_ok(s_axi_araddr) ? pss_pkg::RESP_OKAY : pss_pkg::RESP_SLVERR;
            s_d.rdata = '0;
            if (ridx < 6'(pss_pkg::IMG_WORDS)) begin
                s_d.rdata = s_q.img[ridx[4:0]];
            end else begin
                case (ridx)
                    pss_pkg::R_CTRL: begin
                        s_d.rdata[pss_pkg::C_XFM] = s_q.xfm;
                        s_d.rdata[pss_pkg::C_REQ] = s_q.req;
                        s_d.rdata[pss_pkg::C_BITMAP] = s_q.bitmap;
                        s_d.rdata[pss_pkg::C_PRIV_LO +: 2] = s_q.priv;
                        s_d.rdata[pss_pkg::C_LONG] = s_q.long_mode;
                        s_d.rdata[pss_pkg::C_SEG_RO] = s_q.seg_ro;
                    end
                    pss_pkg::R_SEG_LIMIT: s_d.rdata = s_q.seg_limit;
                    pss_pkg::R_SEG_BASE: s_d.rdata = s_q.seg_base;
                    pss_pkg::R_CFG: s_d.rdata[pss_pkg::NUM_EVT:1] = s_q.avail;
                    pss_pkg::R_STATUS: begin
                        s_d.rdata[pss_pkg::S_EN] = s_q.en;
                        s_d.rdata[pss_pkg::S_GP] = s_q.gp_sticky;
                        s_d.rdata[pss_pkg::S_PEND] = s_q.p.pending;
                        s_d.rdata[pss_pkg::S_FLAGS_LO +: pss_pkg::NUM_EVT] = s_q.p.active;
                    end
                    pss_pkg::R_HEAD: s_d.rdata = s_q.p.head;
                    pss_pkg::R_SIZE: s_d.rdata = {4'h0, s_q.p.size};
                    default: s_d.rdata = '0;
                endcase
            end
        end
        s_d.ar_rdy = !s_d.rvalid;

        // pending record goes to the ring once in user mode
        if (s_q.p.pending && s_q.en && s_q.priv == pss_pkg::PRIV_USER) begin
            s_d.store_pulse = 1'b1;
            s_d.p.pending = 1'b0;
        end

        case (s_q.op)
            pss_pkg::OP_SAVE: begin
                if (!s_q.xfm) begin
                    // feature off: image untouched
                end else if (s_q.p.cbaddr == '0) begin
                    s_d.bitmap = 1'b0;
                end else begin
                    s_d.img[pss_pkg::W_CBADDR_LO] = s_q.p.cbaddr[31:0];
                    s_d.img[pss_pkg::W_CBADDR_HI] = s_q.p.cbaddr[63:32];
                    s_d.img[pss_pkg::W_FLAGS] = {25'h0, s_q.p.active, 1'b0};
                    s_d.img[pss_pkg::W_HEAD] = s_q.p.head;
                    s_d.img[pss_pkg::W_BASE_LO] = s_q.p.base[31:0];
                    s_d.img[pss_pkg::W_BASE_HI] = s_q.p.base[63:32];
                    s_d.img[pss_pkg::W_SIZE] = {4'h0, s_q.p.size};
                    s_d.img[pss_pkg::W_FILT] = s_q.p.filters;
                    for (int i = 0; i < pss_pkg::REC_WORDS; i++) begin
                        s_d.img[32'(pss_pkg::W_REC) + i] =
                            s_q.p.pending ? s_q.p.record[i] : 32'h0000_0000;
                    end
                    for (int i = 1; i <= pss_pkg::NUM_EVT; i++) begin
                        s_d.img[32'(pss_pkg::W_CNT) + i - 1] = s_q.p.count[i];
                    end
                    s_d.bitmap = 1'b1;
                end
            end
            pss_pkg::OP_RESTORE: begin
                if (!s_q.xfm) begin
                    if (s_q.bitmap) begin
                        s_d.gp_pulse = 1'b1;
                        s_d.gp_sticky = 1'b1;
                    end
                end else if (!s_q.req) begin
                end else if (!s_q.bitmap) begin
                    s_d.p = '0;
                end else begin
                    np = '0;
                    np.cbaddr = {s_q.img[pss_pkg::W_CBADDR_HI], s_q.img[pss_pkg::W_CBADDR_LO]};
                    szr = s_q.img[pss_pkg::W_SIZE][SIZE_W_L-1:0];
                    if (np.cbaddr == '0 || szr < MIN_SZ) begin
                        np = '0;
                    end else begin
                        szr = rnd(szr);
                        hd = s_q.img[pss_pkg::W_HEAD];
                        if (hd > {4'h0, szr - REC_SZ}) begin
                            hd = '0;
                        end
                        np.head = hd - (hd % {4'h0, REC_SZ});
                        np.size = szr;
                        np.base = {s_q.img[pss_pkg::W_BASE_HI], s_q.img[pss_pkg::W_BASE_LO]};
                        np.filters = s_q.img[pss_pkg::W_FILT];
                        np.active = s_q.img[pss_pkg::W_FLAGS][pss_pkg::NUM_EVT:1]
                            & s_q.avail;
                        for (int i = 1; i <= pss_pkg::NUM_EVT; i++) begin
                            if (np.active[i]) begin
                                np.count[i] = s_q.img[32'(pss_pkg::W_CNT) + i - 1];
                            end
                        end
                        for (int i = 0; i < pss_pkg::REC_WORDS; i++) begin
                            np.record[i] = s_q.img[32'(pss_pkg::W_REC) + i];
                        end
                        np.pending = s_q.img[pss_pkg::W_REC][7:0] != 8'h00;
                        if (s_q.priv != pss_pkg::PRIV_KERNEL) begin
                            if (!range_ok(np.cbaddr, 32'(CB_SIZE), s_q.long_mode,
                                          s_q.seg_base, s_q.seg_limit, s_q.seg_ro)
                                || !range_ok(np.base, {4'h0, szr}, s_q.long_mode,
                                             s_q.seg_base, s_q.seg_limit, s_q.seg_ro)) begin
                                np = '0;
                            end
                        end
                    end
                    s_d.p = np;
                end
            end
            default: begin
            end
        endcase

        s_d.en = s_d.p.cbaddr != '0;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign s_axi_awready = s_q.aw_rdy;
    assign s_axi_wready = s_q.w_rdy;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = s_q.ar_rdy;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign profiling_enabled = s_q.en;
    assign gp_fault = s_q.gp_pulse;
    assign record_store = s_q.store_pulse;

endmodule : pss_profiling_state_save_restore

`default_nettype wire

//--- testbench/pss_checker.sv
/* assertion checker for the profiling save/restore block.
   assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module pss_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic [pss_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic profiling_enabled,
    input wire logic gp_fault,
    input wire logic record_store
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence rd_high;
        rd_take ##0 (s_axi_araddr > 8'h9C);
    endsequence
    write_answer_a: assert property (wr_take |-> ##2 s_axi_bvalid)
        else $error("late write response");
    resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    read_answer_a: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
        else $error("late read data");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    unmapped_read_a: assert property (rd_high
        |=> s_axi_rresp == pss_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    mapped_read_a: assert property (rd_take ##0 (s_axi_araddr <= 8'h9C)
        |=> s_axi_rresp == pss_pkg::RESP_OKAY)
        else $error("mapped read refused");
    gp_pulse_a: assert property (gp_fault |-> $stable(profiling_enabled) ##1 !gp_fault)
        else $error("fault pulse wrong");
    store_pulse_a: assert property (record_store |-> $past(profiling_enabled) ##1 !record_store)
        else $error("record store pulse wrong");
endmodule : pss_checker
`default_nettype wire

//--- testbench/test_profiling_state_save_restore.sv
/* self-checking bench for the profiling save/restore block.
   assumes the package, design and checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module test_profiling_state_save_restore;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic bready = 1'h0;
    logic arvalid = 1'h0;
    logic rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, en, gp, st;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [33:0] expq [$];
    logic [31:0] r [0:7];
    int num_errors = 0;
    int cmp_count = 0;
    int seed = 90336;
    int gps = 0;
    int stores = 0;

    pss_profiling_state_save_restore dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .profiling_enabled(en),
        .gp_fault(gp), .record_store(st)
    );

    initial forever #10 aclk = ~aclk;

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // index is the word index; byte address is four times it
    task automatic wr(input logic [5:0] i, input logic [31:0] d, input logic [1:0] rs = 2'h0);
        @(posedge aclk);
        awaddr <= {i, 2'h0};
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'($random(seed));
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        if (!bready) begin
            bready <= 1'h1;
            @(posedge aclk);
        end
        bready <= 1'h0;
        check("bresp", 32'(bresp), 32'(rs));
    endtask : wr

    task automatic rd(input logic [5:0] i, input logic [31:0] e, input logic [1:0] rs = 2'h0);
        expq.push_back({rs, e});
        @(posedge aclk);
        araddr <= {i, 2'h0};
        arvalid <= 1'h1;
        rready <= 1'($random(seed));
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        if (!rready) begin
            rready <= 1'h1;
            @(posedge aclk);
        end
        rready <= 1'h0;
    endtask : rd

    task automatic cmd(input logic [31:0] v);
        wr(pss_pkg::R_CMD, v);
        repeat (5) @(posedge aclk);
    endtask : cmd

    task automatic vc(input logic [31:0] cb, input logic [31:0] bs, input logic [31:0] c,
                      input logic e);
        wr(pss_pkg::W_CBADDR_LO, cb);
        wr(pss_pkg::W_BASE_LO, bs);
        wr(pss_pkg::R_CTRL, c);
        cmd(32'h2);
        check("enabled", 32'(en), 32'(e));
    endtask : vc

    task automatic print_verdict;
        if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict

    always @(posedge aclk) begin
        if (rvalid && rready && expq.size() > 0) begin
            check("rdata", rdata, expq[0][31:0]);
            check("rresp", 32'(rresp), 32'(expq[0][33:32]));
            void'(expq.pop_front());
        end
        if (gp === 1'h1) gps++;
        if (st === 1'h1) stores++;
    end

    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        print_verdict();
    end

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        for (int i = 0; i < 8; i++) r[i] = $random(seed);
        rd(pss_pkg::R_STATUS, 32'h0);
        wr(pss_pkg::R_CTRL, 32'h07);
        cmd(32'h1);
        rd(pss_pkg::R_CTRL, 32'h03);
        wr(pss_pkg::W_CBADDR_LO, r[0] | 32'h1);
        wr(pss_pkg::W_CBADDR_HI, r[1]);
        wr(pss_pkg::W_FLAGS, 32'h7E);
        wr(pss_pkg::W_HEAD, 32'h64);
        wr(pss_pkg::W_BASE_LO, r[2]);
        wr(pss_pkg::W_SIZE, 32'hC8);
        wr(pss_pkg::W_FILT, r[4]);
        wr(pss_pkg::W_REC, 32'h05);
        for (int i = 0; i < 6; i++) wr(6'(16 + i), r[5] ^ 32'(i));
        wr(pss_pkg::R_CFG, 32'h2A);
        wr(pss_pkg::R_CTRL, 32'h07);
        cmd(32'h2);
        rd(pss_pkg::R_STATUS, 32'h155);
        rd(pss_pkg::R_HEAD, 32'h60);
        rd(pss_pkg::R_SIZE, 32'hC0);
        cmd(32'h1);
        rd(pss_pkg::W_CBADDR_LO, r[0] | 32'h1);
        rd(pss_pkg::W_CBADDR_HI, r[1]);
        rd(pss_pkg::W_FLAGS, 32'h2A);
        rd(pss_pkg::W_HEAD, 32'h60);
        rd(pss_pkg::W_BASE_LO, r[2]);
        rd(pss_pkg::W_SIZE, 32'hC0);
        rd(pss_pkg::W_FILT, r[4]);
        rd(pss_pkg::W_REC, 32'h05);
        for (int i = 0; i < 6; i++) rd(6'(16 + i), i % 2 ? 32'h0 : r[5] ^ 32'(i));
        rd(pss_pkg::R_CTRL, 32'h07);
        wr(pss_pkg::R_CTRL, 32'h37);
        repeat (6) @(posedge aclk);
        check("stores", 32'(stores), 32'h1);
        rd(pss_pkg::R_STATUS, 32'h151);
        wr(pss_pkg::R_CTRL, 32'h04);
        cmd(32'h2);
        check("gp count", 32'(gps), 32'h1);
        rd(pss_pkg::R_STATUS, 32'h153);
        wr(pss_pkg::R_STATUS, 32'h2);
        rd(pss_pkg::R_STATUS, 32'h151);
        for (int i = 1; i < 3; i++) begin
            wr(pss_pkg::R_CTRL, 32'(i));
            cmd(32'h2);
            rd(pss_pkg::R_STATUS, 32'h151);
        end
        wr(pss_pkg::R_CTRL, 32'h03);
        cmd(32'h2);
        rd(pss_pkg::R_STATUS, 32'h0);
        rd(pss_pkg::R_HEAD, 32'h0);
        wr(pss_pkg::W_SIZE, 32'h80);
        wr(pss_pkg::W_HEAD, 32'h70);
        wr(pss_pkg::R_CTRL, 32'h07);
        cmd(32'h2);
        rd(pss_pkg::R_HEAD, 32'h0);
        check("enabled", 32'(en), 32'h1);
        wr(pss_pkg::W_SIZE, 32'h3F);
        cmd(32'h2);
        rd(pss_pkg::R_STATUS, 32'h0);
        wr(pss_pkg::W_SIZE, 32'h80);
        wr(pss_pkg::R_SEG_LIMIT, 32'hFFFF);
        vc(32'hFF80, 32'hFF80, 32'h17, 1'h1);
        vc(32'hFF81, 32'h2000, 32'h17, 1'h0);
        vc(32'h1000, 32'hFF81, 32'h17, 1'h0);
        vc(32'h1000, 32'h2000, 32'h97, 1'h0);
        vc(32'hFF81, 32'hFF81, 32'h07, 1'h1);
        check("gp count", 32'(gps), 32'h1);
        wr(pss_pkg::R_CTRL, 32'h02);
        cmd(32'h1);
        rd(pss_pkg::R_CTRL, 32'h02);
        rd(6'h28, 32'h0, pss_pkg::RESP_SLVERR);
        wr(6'h28, r[6], pss_pkg::RESP_SLVERR);
        rd(pss_pkg::R_CMD, 32'h0);
        @(posedge aclk);
        print_verdict();
    end
endmodule : test_profiling_state_save_restore

bind pss_profiling_state_save_restore pss_checker chk (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .profiling_enabled, .gp_fault, .record_store
);
`default_nettype wire
